// >>> hdl/eeprom_seq_params.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Included by the sequencer files
// Notes: Definitions only
`ifndef EEPROM_SEQ_PARAMS_SVH
`define EEPROM_SEQ_PARAMS_SVH
`define OFS_CONTROL 12'h000
`define OFS_MODE 12'h004
`define OFS_ADDR_HIGH 12'h008
`define OFS_ADDR_LOW 12'h00c
`define OFS_DATA 12'h010
`define OFS_TRIGGER 12'h014
`define OFS_LOW_BOUND 12'h018
`define OFS_REGION 12'h01c
`define OFS_STATUS 12'h020
`define BIT_ENABLE 7
`define BIT_DONE 0
`define BIT_BUSY 1
`define MODE_STANDBY 8'h00
`define MODE_EE_PROGRAM 8'hc8
`define MODE_EE_READ 8'hc0
`define KEY_FIRST 8'h46
`define KEY_SECOND 8'hb9
`define EE_ADDR_W 9
`define EE_DEPTH 512
`define FLASH_TOP 13'h1fff
`define BOOT_STEP 13'h0200
`define BOOT_MAX_STEPS 3'h7
`define RST_BOOT_STEPS 3'h3
`define RST_LOW_BOUND 8'h1a
`define PROGRAM_TIME_US 2
`define PROGRAM_CYCLES ((`PROGRAM_TIME_US * 1000) / 10)
`define READ_CYCLES 2
`endif

// >>> hdl/eeprom_seq_pkg.sv
// Purpose: Types shared by the sequencer files
// Assumes: Constants come from the params header
// Notes: Types only
package eeprom_seq_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_PROG = 4'b0100,
    ST_DONE = 4'b1000
  } engine_state_type;
  typedef enum logic [1:0] {
    RUN_BOOT = 2'h0,
    RUN_CODE = 2'h1,
    RUN_DATA = 2'h2
  } run_region_type;
endpackage : eeprom_seq_pkg

// >>> hdl/eeprom_array.sv
// Purpose: 512-byte storage with one synchronous port
// Assumes: One access per cycle
// Notes: Byte writes overwrite directly, no erase needed
`timescale 1ns/1ps
`include "eeprom_seq_params.svh"
module eeprom_array (
  input wire logic hclk,
  input wire logic wr_en,
  input wire logic [`EE_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:`EE_DEPTH-1];
  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : eeprom_array

// >>> hdl/eeprom_access_sequencer.sv
// What this block does
// - Boot region code may write code and data regions; code only data.
// - Boot region size is off or 0.5KB steps to 3.5KB in 8KB.
// - Data region spans low-bound register up to boot region start.
// - Low bound comes from hardware option or code-region software.
// - Byte program works at any address without erase.
// - Operations never stall the CPU; bus answers at once.
// - Busy flag is high while an operation runs.
// - Done flag sets on completion and stays until cleared.
// - Only with control bit 7 set is an access processed.
// - Mode 0xc8 selects byte program.
// - Mode 0xc0 selects byte read.
// - Address is high byte joined with low byte; data from data reg.
// - Operation starts after 0x46 then 0xb9 to trigger register.
// - Read result lands in data register.
// - Address wraps onto low 9 bits.
// - Low address byte never carries into the high byte.
// - Writing control bit 0 as 1 clears the done flag.
//
// Purpose: EEPROM byte engine and flash partition checker over AHB-Lite
// Assumes: Single-word transfers; slave always OKAY, zero wait states
// Notes: Flash erase and program sequences are not implemented here
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "eeprom_seq_params.svh"
module eeprom_access_sequencer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [2:0] boot_size_option,
  input wire logic [7:0] low_bound_option,
  input wire logic [1:0] run_region,
  input wire logic [12:0] flash_write_addr,
  output logic flash_write_allowed
);
  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic wr_pend_q, wr_pend_d;
  logic [11:0] addr_q, addr_d;
  logic rd_pend_q, rd_pend_d;
  logic take;
  logic bus_wr;
  logic [7:0] wbyte;

  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bus_wr = wr_pend_q;
  assign wbyte = hwdata[7:0];

  always_comb begin
    wr_pend_d = take && hwrite;
    rd_pend_d = take && !hwrite;
    addr_d = take ? haddr[11:0] : addr_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      addr_q <= addr_d;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic enable_q, enable_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] addr_hi_q, addr_hi_d;
  logic [7:0] addr_lo_q, addr_lo_d;
  logic [7:0] data_q, data_d;
  logic [7:0] low_bound_q, low_bound_d;
  logic bound_loaded_q, bound_loaded_d;
  logic key_armed_q, key_armed_d;
  logic done_q, done_d;
  logic start_read, start_prog, finish;
  logic [7:0] ee_rdata;
  logic load_read;
  logic mode_ok;
  logic busy;

  assign mode_ok = (mode_q == `MODE_EE_PROGRAM) ||
                   (mode_q == `MODE_EE_READ);

  always_comb begin
    enable_d = enable_q;
    mode_d = mode_q;
    addr_hi_d = addr_hi_q;
    addr_lo_d = addr_lo_q;
    data_d = data_q;
    low_bound_d = low_bound_q;
    bound_loaded_d = 1'b1;
    key_armed_d = key_armed_q;
    done_d = done_q;
    start_read = 1'b0;
    start_prog = 1'b0;
    if (!bound_loaded_q) begin
      // Strap sampled once after reset release
      low_bound_d = low_bound_option;
    end
    if (bus_wr) begin
      case (addr_q)
        `OFS_CONTROL: begin
          enable_d = wbyte[`BIT_ENABLE];
          if (wbyte[`BIT_DONE]) begin
            done_d = 1'b0;
          end
        end
        `OFS_MODE: mode_d = wbyte;
        `OFS_ADDR_HIGH: addr_hi_d = wbyte;
        // Plain byte store: no carry path into the high byte
        `OFS_ADDR_LOW: addr_lo_d = wbyte;
        `OFS_DATA: data_d = wbyte;
        `OFS_LOW_BOUND: begin
          if (run_region == eeprom_seq_pkg::RUN_CODE) begin
            low_bound_d = wbyte;
          end
        end
        `OFS_TRIGGER: begin
          if (key_armed_q && wbyte == `KEY_SECOND) begin
            key_armed_d = 1'b0;
            if (enable_q && !busy) begin
              start_read = (mode_q == `MODE_EE_READ);
              start_prog = (mode_q == `MODE_EE_PROGRAM);
            end
          end else begin
            key_armed_d = (wbyte == `KEY_FIRST);
          end
        end
        default: ;
      endcase
    end
    if (load_read) begin
      data_d = ee_rdata;
    end
    if (finish) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_q <= 1'b0;
      mode_q <= `MODE_STANDBY;
      addr_hi_q <= 8'h00;
      addr_lo_q <= 8'h00;
      data_q <= 8'h00;
      low_bound_q <= `RST_LOW_BOUND;
      bound_loaded_q <= 1'b0;
      key_armed_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      mode_q <= mode_d;
      addr_hi_q <= addr_hi_d;
      addr_lo_q <= addr_lo_d;
      data_q <= data_d;
      low_bound_q <= low_bound_d;
      bound_loaded_q <= bound_loaded_d;
      key_armed_q <= key_armed_d;
      done_q <= done_d;
    end
  end

  // ****************************************************************
  // Engine
  // ****************************************************************
  eeprom_seq_pkg::engine_state_type state_q, state_d;
  logic [7:0] count_q, count_d;
  logic [`EE_ADDR_W-1:0] op_addr_q, op_addr_d;
  logic [7:0] op_data_q, op_data_d;
  logic ee_wr;

  assign busy = (state_q != eeprom_seq_pkg::ST_IDLE);

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    op_addr_d = op_addr_q;
    op_data_d = op_data_q;
    finish = 1'b0;
    load_read = 1'b0;
    ee_wr = 1'b0;
    case (state_q)
      eeprom_seq_pkg::ST_IDLE: begin
        // High bits beyond the array are dropped
        op_addr_d = {addr_hi_q[0], addr_lo_q};
        op_data_d = data_q;
        if (start_read) begin
          state_d = eeprom_seq_pkg::ST_READ;
          count_d = 8'(`READ_CYCLES);
        end else if (start_prog) begin
          state_d = eeprom_seq_pkg::ST_PROG;
          count_d = 8'(`PROGRAM_CYCLES);
        end
      end
      eeprom_seq_pkg::ST_READ: begin
        count_d = count_q - 8'h01;
        if (count_q == 8'h01) begin
          load_read = 1'b1;
          state_d = eeprom_seq_pkg::ST_DONE;
        end
      end
      eeprom_seq_pkg::ST_PROG: begin
        count_d = count_q - 8'h01;
        if (count_q == 8'h01) begin
          ee_wr = 1'b1;
          state_d = eeprom_seq_pkg::ST_DONE;
        end
      end
      eeprom_seq_pkg::ST_DONE: begin
        finish = 1'b1;
        state_d = eeprom_seq_pkg::ST_IDLE;
      end
      default: state_d = eeprom_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= eeprom_seq_pkg::ST_IDLE;
      count_q <= 8'h00;
      op_addr_q <= 9'h000;
      op_data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      op_addr_q <= op_addr_d;
      op_data_q <= op_data_d;
    end
  end

  eeprom_array u_array (
    .hclk(hclk),
    .wr_en(ee_wr),
    .addr(op_addr_q),
    .wdata(op_data_q),
    .rdata(ee_rdata)
  );

  // ****************************************************************
  // Flash partition check
  // ****************************************************************
  logic [13:0] boot_start;
  logic [12:0] data_low;
  logic in_data, in_code;

  // Size option 0 disables the region; steps clamp at seven
  // One bit wider so a disabled region starts just past the top
  assign boot_start = {1'b0, `FLASH_TOP} + 14'h0001 -
                      14'(boot_size_option) * {1'b0, `BOOT_STEP};
  assign data_low = {low_bound_q[6:0], 6'h00};
  assign in_data = (flash_write_addr >= data_low) &&
                   ({1'b0, flash_write_addr} < boot_start);
  assign in_code = (flash_write_addr < data_low);

  always_comb begin
    case (run_region)
      eeprom_seq_pkg::RUN_BOOT:
        flash_write_allowed = in_data || in_code;
      eeprom_seq_pkg::RUN_CODE:
        flash_write_allowed = in_data;
      default: flash_write_allowed = 1'b0;
    endcase
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h00000000;
    case (haddr[11:0])
      `OFS_CONTROL: rdata_d[7:0] = {enable_q, 6'h00, done_q};
      `OFS_MODE: rdata_d[7:0] = mode_q;
      `OFS_ADDR_HIGH: rdata_d[7:0] = addr_hi_q;
      `OFS_ADDR_LOW: rdata_d[7:0] = addr_lo_q;
      `OFS_DATA: rdata_d[7:0] = data_q;
      `OFS_LOW_BOUND: rdata_d[7:0] = low_bound_q;
      `OFS_REGION: rdata_d[13:0] = boot_start;
      `OFS_STATUS: rdata_d[1:0] = {busy, done_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata <= rdata_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_done_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    finish |=> done_q) else $error("done flag not set");
  a_busy_run: assert property (@(posedge hclk) disable iff (!hresetn)
    (start_read || start_prog) |=> busy[*2])
    else $error("busy not held");
  a_no_start_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !enable_q |-> !(start_read || start_prog))
    else $error("start while disabled");
  a_prog_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    start_prog |-> mode_q == `MODE_EE_PROGRAM)
    else $error("program bad mode");
  a_read_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    start_read |-> mode_q == `MODE_EE_READ)
    else $error("read bad mode");
  a_key_order: assert property (@(posedge hclk) disable iff (!hresetn)
    (start_read || start_prog) |-> key_armed_q && wbyte == `KEY_SECOND)
    else $error("start without key");
  a_read_lands: assert property (@(posedge hclk) disable iff (!hresetn)
    start_read |-> ##3 (data_q == $past(ee_rdata)) ##1 done_q)
    else $error("read data missing");
  a_addr_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == eeprom_seq_pkg::ST_IDLE) |=>
      op_addr_q == {$past(addr_hi_q[0]), $past(addr_lo_q)})
    else $error("address wrong");
  a_code_limit: assert property (@(posedge hclk) disable iff (!hresetn)
    (run_region == eeprom_seq_pkg::RUN_CODE && flash_write_allowed)
      |-> in_data) else $error("code wrote outside data");
  a_never_stall: assert property (@(posedge hclk) disable iff (!hresetn)
    busy |-> hreadyout) else $error("bus stalled");
endmodule : eeprom_access_sequencer

// >>> dv/eeprom_access_sequencer_bench.sv
// Purpose: Register-level bench for the EEPROM byte engine
// Assumes: Zero wait states; hready is fed from hreadyout
// Notes: Boot option 3 at start, later set to 0 and 7; low bound strap 0x60 fixed for the run
`timescale 1ns/1ps
`include "eeprom_seq_params.svh"
module eeprom_access_sequencer_bench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, allowed;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, run_region;
  logic [2:0] hsize, boot_opt;
  logic [7:0] lb_opt;
  logic [12:0] faddr;
  int miscompares, total_checks;
  assign hready = hreadyout;
  eeprom_access_sequencer i_eeprom_access_sequencer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .boot_size_option(boot_opt),
    .low_bound_option(lb_opt), .run_region(run_region),
    .flash_write_addr(faddr), .flash_write_allowed(allowed)
  );
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ****************************************
  // Bus tasks and checks
  // ****************************************
  task results;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus_wait;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      miscompares++;
      $display("[FAIL] hready expected 1 seen %b", hready);
      results();
    end
  endtask : bus_wait
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, a};
    bus_wait();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    bus_wait();
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rdchk(input string what, input logic [11:0] a,
                       input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rdchk
  // Busy low and done high, then done is cleared again
  task automatic finish_op;
    int n;
    n = 0;
    do begin
      xfer(1'b0, `OFS_STATUS, 32'h0);
      n++;
    end while ((rd & 32'h3) !== 32'h1 && n < 400);
    check("status end", rd & 32'h3, 32'h1);
    if ((rd & 32'h3) !== 32'h1) begin
      results();
    end
    rdchk("done held", `OFS_CONTROL, 32'h81);
    wr(`OFS_CONTROL, 8'h81);
    rdchk("done clear", `OFS_STATUS, 32'h0);
  endtask : finish_op
  task automatic ee_op(input logic [7:0] mode, hi, lo, d);
    wr(`OFS_CONTROL, 8'h80);
    wr(`OFS_MODE, mode);
    wr(`OFS_ADDR_HIGH, hi);
    wr(`OFS_ADDR_LOW, lo);
    wr(`OFS_DATA, d);
    wr(`OFS_TRIGGER, `KEY_FIRST);
    wr(`OFS_TRIGGER, `KEY_SECOND);
  endtask : ee_op
  task automatic ee_rd(input logic [7:0] hi, lo, exp);
    ee_op(`MODE_EE_READ, hi, lo, 8'h00);
    finish_op();
    rdchk("read data", `OFS_DATA, {24'h0, exp});
  endtask : ee_rd
  task automatic ee_rt(input logic [7:0] hi, lo, d, rhi);
    ee_op(`MODE_EE_PROGRAM, hi, lo, d);
    rdchk("busy", `OFS_STATUS, 32'h2);
    finish_op();
    ee_rd(rhi, lo, d);
  endtask : ee_rt
  // Engine must stay idle and leave the data register alone
  task automatic refuse(input logic [7:0] ctl, mode, k2);
    wr(`OFS_CONTROL, ctl);
    wr(`OFS_MODE, mode);
    wr(`OFS_TRIGGER, `KEY_FIRST);
    wr(`OFS_TRIGGER, k2);
    rdchk("idle", `OFS_STATUS, 32'h0);
    rdchk("data kept", `OFS_DATA, 32'h77);
  endtask : refuse
  task automatic perm(input logic [1:0] run, input logic [12:0] a,
                      input logic exp);
    run_region <= run;
    faddr <= a;
    @(posedge hclk);
    check("allowed", {31'h0, allowed}, {31'h0, exp});
  endtask : perm
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    boot_opt = 3'h3;
    lb_opt = 8'h60;
    run_region = 2'h1;
    faddr = 13'h0;
    miscompares = 0;
    total_checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("control", `OFS_CONTROL, 32'h0);
    rdchk("mode", `OFS_MODE, 32'h0);
    rdchk("addr high", `OFS_ADDR_HIGH, 32'h0);
    rdchk("addr low", `OFS_ADDR_LOW, 32'h0);
    rdchk("data", `OFS_DATA, 32'h0);
    rdchk("status", `OFS_STATUS, 32'h0);
    rdchk("low bound", `OFS_LOW_BOUND, 32'h60);
    // Three 0.5KB steps below the top of the 8KB flash
    rdchk("boot start", `OFS_REGION, 32'h1a00);
    rdchk("trigger", `OFS_TRIGGER, 32'h0);
    wr(12'h100, 8'hff);
    rdchk("unmapped", 12'h100, 32'h0);
    ee_rt(8'h03, 8'h23, 8'ha5, 8'h01);
    ee_rt(8'h01, 8'h23, 8'h5a, 8'h01);
    ee_rt(8'h00, 8'hff, 8'h11, 8'h00);
    ee_rt(8'h01, 8'hff, 8'h22, 8'h01);
    ee_rd(8'h00, 8'hff, 8'h11);
    wr(`OFS_ADDR_HIGH, 8'h01);
    wr(`OFS_ADDR_LOW, 8'h23);
    wr(`OFS_DATA, 8'h77);
    refuse(8'h80, `MODE_EE_READ, 8'h47);
    refuse(8'h00, `MODE_EE_READ, `KEY_SECOND);
    refuse(8'h80, 8'hc3, `KEY_SECOND);
    perm(2'h0, 13'h0100, 1'b1);
    perm(2'h0, 13'h1900, 1'b1);
    perm(2'h0, 13'h1a00, 1'b0);
    perm(2'h1, 13'h0100, 1'b0);
    perm(2'h1, 13'h1800, 1'b1);
    perm(2'h1, 13'h1a00, 1'b0);
    perm(2'h0, 13'h1400, 1'b1);
    wr(`OFS_LOW_BOUND, 8'h50);
    rdchk("bound kept", `OFS_LOW_BOUND, 32'h60);
    perm(2'h1, 13'h1400, 1'b0);
    wr(`OFS_LOW_BOUND, 8'h50);
    rdchk("bound set", `OFS_LOW_BOUND, 32'h50);
    perm(2'h1, 13'h1400, 1'b1);
    // Disabled boot region hands the data region the top of flash
    boot_opt <= 3'h0;
    rdchk("boot off", `OFS_REGION, 32'h2000);
    perm(2'h1, 13'h1f00, 1'b1);
    boot_opt <= 3'h7;
    rdchk("boot max", `OFS_REGION, 32'h1200);
    check("hresp", {31'h0, hresp}, 32'h0);
    wr(`OFS_MODE, `MODE_STANDBY);
    wr(`OFS_CONTROL, 8'h00);
    rdchk("closed", `OFS_CONTROL, 32'h0);
    results();
  end
endmodule : eeprom_access_sequencer_bench
